// ### design/low_hold_filter.v
// Purpose: Passes a level only after it stays high for a set number of cycles
// Assumes: Input already synchronised to ref_clk
// Notes: Used for the reset pin noise filter and the port hold timer
`timescale 1ns/1ns
module low_hold_filter #(
  parameter WIDTH = 32,
  parameter [WIDTH-1:0] HOLD = 32'h1
) (
  // Clock and reset
  input wire ref_clk,
  input wire arst_n,
  // Level in and filtered level out
  input wire level,
  output reg held
);
  reg [WIDTH-1:0] count;

  always @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      count <= {WIDTH{1'b0}};
      held <= 1'b0;
    end
    else if (!level)
    begin
      count <= {WIDTH{1'b0}};
      held <= 1'b0;
    end
    else if (count >= HOLD - 1'b1)
      held <= 1'b1;
    else
      count <= count + 1'b1;
  end
endmodule

// ### design/supply_detect_load_mode_ctrl.v
// Purpose: Supply detector and heavy-load/LCD control registers, initial reset merge
// Assumes: AXI4-Lite master keeps one read and one write in flight at most
// Notes: Analog compare result arrives on supplyBelowCrit for the selected criterion
`timescale 1ns/1ns
`include "supply_detect_regs.vh"
module supply_detect_load_mode_ctrl #(
  parameter [1:0] PORT_COMBO = `PORT_COMBO_ALL4,
  parameter [31:0] PORT_HOLD_CYCLES = `CLK_PER_MS * `PORT_HOLD_MS,
  parameter [31:0] PIN_HOLD_CYCLES = `CLK_PER_MS * `PIN_HOLD_MS
) (
  // Clock and reset
  input wire ref_clk,
  input wire arst_n,
  // AXI4-Lite write address
  input wire [13:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // AXI4-Lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read address
  input wire [13:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  // AXI4-Lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Analog detector interface
  input wire supplyBelowCrit,
  output reg detectorOn,
  output reg [1:0] thresholdSelect,
  // LCD bias and drive controls
  output reg heavyLoadMode,
  output reg biasRegulateLevelOne,
  output reg lcdDutySelect,
  output reg lcdLightAll,
  output reg lcdBlankAll,
  // Initial reset sources and merged output
  input wire resetPin_n,
  input wire [3:0] inputPortLowPins,
  input wire oscRunning,
  input wire watchdogReset,
  output reg initialReset
);
  // Synchronisers, filter outputs and reset merge
  reg [1:0] syncPin;
  reg [3:0] syncPort0;
  reg [3:0] syncPort1;
  reg [1:0] syncOsc;
  reg [1:0] syncWdt;
  reg [1:0] syncBelow;
  wire pinLowHeld;
  wire portLowHeld;
  reg portCombo;
  reg mergedReset;
  reg [3:0] resetCause;
  wire oscRequest;
  wire wdtRequest;

  // Register state
  reg [1:0] thrSel;
  reg detEn;
  reg heavyLoad;
  reg duty;
  reg lightAll;
  reg blankAll;
  reg [31:0] readImage;
  wire wrLcdLoad;
  wire wrSupply;

  // Reset image of the LCD/load register, one constant per field
  localparam [3:0] LCD_RST = `RST_LCD_LOAD;
  localparam [0:0] RST_HEAVY = LCD_RST[`BIT_HEAVY_LOAD];
  localparam [0:0] RST_DUTY = LCD_RST[`BIT_DUTY];
  localparam [0:0] RST_LIGHT = LCD_RST[`BIT_LIGHT_ALL];
  localparam [0:0] RST_BLANK = LCD_RST[`BIT_BLANK_ALL];

  // Write channel holding
  reg awHeld;
  reg wHeld;
  reg [13:0] awAddr;
  reg [31:0] wData;
  reg [3:0] wStrb;
  wire doWrite;

  function validAddr;
    input [13:0] a;
  begin
    validAddr = (a == `ADDR_LCD_LOAD) || (a == `ADDR_SUPPLY) || (a == `ADDR_RESET_STATUS);
  end
  endfunction

  // Detection result: forced high while disabled
  function lowResult;
    input en;
    input below;
  begin
    lowResult = en ? below : 1'b1;
  end
  endfunction

  // Two-flop synchronisers on every pin-side input
  always @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      syncPin <= 2'h0;
      syncPort0 <= 4'hF;
      syncPort1 <= 4'hF;
      syncOsc <= 2'h0;
      syncWdt <= 2'h0;
      syncBelow <= 2'h0;
    end
    else
    begin
      syncPin <= {syncPin[0], ~resetPin_n};
      syncPort0 <= inputPortLowPins;
      syncPort1 <= syncPort0;
      syncOsc <= {syncOsc[0], oscRunning};
      syncWdt <= {syncWdt[0], watchdogReset};
      syncBelow <= {syncBelow[0], supplyBelowCrit};
    end
  end

  // Build-time pin combination for port reset
  always @*
  begin
    case (PORT_COMBO)
      `PORT_COMBO_PAIR: portCombo = ~syncPort1[0] & ~syncPort1[1];
      `PORT_COMBO_TRIO: portCombo = ~(|syncPort1[2:0]);
      `PORT_COMBO_ALL4: portCombo = ~(|syncPort1);
      default: portCombo = 1'b0;
    endcase
  end

  low_hold_filter #(.WIDTH(32), .HOLD(PIN_HOLD_CYCLES)) pinFilter (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .level(syncPin[1]),
    .held(pinLowHeld)
  );

  low_hold_filter #(.WIDTH(32), .HOLD(PORT_HOLD_CYCLES)) portFilter (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .level(portCombo),
    .held(portLowHeld)
  );

  // Oscillator not yet running, or watchdog expiry, each request reset
  assign oscRequest = ~syncOsc[1];
  assign wdtRequest = syncWdt[1];

  always @*
  begin
    mergedReset = pinLowHeld | portLowHeld | oscRequest | wdtRequest;
  end

  // Merged reset output and latched cause bits
  always @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      initialReset <= 1'b1;
      resetCause <= 4'h0;
    end
    else
    begin
      initialReset <= mergedReset;
      // Sticky: only the external reset clears a cause bit
      if (mergedReset)
        resetCause <= resetCause | {wdtRequest, oscRequest, portLowHeld, pinLowHeld};
    end
  end

  // Commit once both halves are held and the last response has been taken
  assign doWrite = awHeld && wHeld && !s_axi_bvalid;
  assign wrLcdLoad = doWrite && wStrb[0] && (awAddr == `ADDR_LCD_LOAD);
  assign wrSupply = doWrite && wStrb[0] && (awAddr == `ADDR_SUPPLY);

  // Write path: address and data taken in either order
  always @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddr <= 14'h0;
      wData <= 32'h0;
      wStrb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end
    else
    begin
      // Readies pulse for one cycle, so a held channel is never taken twice
      s_axi_awready <= !awHeld && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready <= !wHeld && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        awHeld <= 1'b1;
        awAddr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (doWrite)
      begin
        awHeld <= 1'b0;
        wHeld <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= validAddr(awAddr) ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Control registers; held at defaults while initial reset is asserted
  always @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      detEn <= `RST_DET_EN;
      heavyLoad <= RST_HEAVY;
      duty <= RST_DUTY;
      lightAll <= RST_LIGHT;
      blankAll <= RST_BLANK;
    end
    else if (initialReset)
    begin
      detEn <= `RST_DET_EN;
      heavyLoad <= RST_HEAVY;
      duty <= RST_DUTY;
      lightAll <= RST_LIGHT;
      blankAll <= RST_BLANK;
    end
    else
    begin
      if (wrLcdLoad)
      begin
        heavyLoad <= wData[`BIT_HEAVY_LOAD];
        duty <= wData[`BIT_DUTY];
        lightAll <= wData[`BIT_LIGHT_ALL];
        blankAll <= wData[`BIT_BLANK_ALL];
      end
      if (wrSupply)
        detEn <= wData[`BIT_DET_EN];
    end
  end

  // Threshold select has no reset, stays as last written
  always @(posedge ref_clk)
  begin
    if (wrSupply)
      thrSel <= wData[`BIT_THR_HI:`BIT_THR_LO];
  end

  // Outputs to the analog detector
  always @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      detectorOn <= `RST_DET_EN;
      thresholdSelect <= `THR_2V2;
    end
    else
    begin
      detectorOn <= detEn;
      thresholdSelect <= thrSel;
    end
  end

  // Outputs to the LCD bias generator and driver
  always @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      heavyLoadMode <= RST_HEAVY;
      biasRegulateLevelOne <= RST_HEAVY;
      lcdDutySelect <= RST_DUTY;
      lcdLightAll <= RST_LIGHT;
      lcdBlankAll <= RST_BLANK;
    end
    else
    begin
      heavyLoadMode <= heavyLoad;
      biasRegulateLevelOne <= heavyLoad;
      lcdDutySelect <= duty;
      lcdLightAll <= lightAll;
      lcdBlankAll <= blankAll;
    end
  end

  // Read image of the addressed word; unmapped words read as zero
  always @*
  begin
    case (s_axi_araddr)
      `ADDR_LCD_LOAD: readImage = {28'h0, blankAll, lightAll, duty, heavyLoad};
      `ADDR_SUPPLY: readImage = {28'h0, lowResult(detEn, syncBelow[1]), detEn, thrSel};
      `ADDR_RESET_STATUS: readImage = {28'h0, resetCause};
      default: readImage = 32'h0;
    endcase
  end

  // Read path
  always @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= validAddr(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
        s_axi_rdata <= readImage;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// ### design/supply_detect_regs.vh
// Purpose: Offsets, field positions, reset values and timing for supply/load control
// Assumes: AXI4-Lite register slave, 32-bit data, 10 MHz ref_clk
// Notes: Printed offsets are not word multiples, so they are indices; byte address is 4x
// Function
// - Threshold select picks 2.2/2.5/3.1/4.2 V criterion
// - Threshold select bits undefined after reset
// - Enable bit switches detector on/off, reads back
// - Enable bit clears to zero on reset
// - Result reads 1 when supply below criterion
// - Result reads 1 while detector disabled
// - Heavy-load bit enters/leaves mode, reads back
// - Heavy-load bit clears to zero on reset
// - Mode selects which bias level is regulated
// - Duty bit selects 1/8 or 1/16, resets 0
// - Blank-all resets 1, light-all resets 0
// - Any of four sources asserts initial reset
// - Build option picks input-port pin combination
// - Port reset needs 2 s of joint low
// - Reset pin filter rejects pulses under 2 ms
// - Oscillation detector holds reset until running
`ifndef SUPPLY_DETECT_REGS_VH
`define SUPPLY_DETECT_REGS_VH

`define IDX_LCD_LOAD 12'hF71
`define IDX_SUPPLY 12'hF73
`define ADDR_LCD_LOAD 14'h3DC4
`define ADDR_SUPPLY 14'h3DCC
`define ADDR_RESET_STATUS 14'h3DD0

`define BIT_HEAVY_LOAD 0
`define BIT_DUTY 1
`define BIT_LIGHT_ALL 2
`define BIT_BLANK_ALL 3
`define BIT_THR_LO 0
`define BIT_THR_HI 1
`define BIT_DET_EN 2
`define BIT_LOW_RESULT 3

`define RST_LCD_LOAD 4'h8
`define RST_DET_EN 1'b0

`define THR_2V2 2'h0
`define THR_2V5 2'h1
`define THR_3V1 2'h2
`define THR_4V2 2'h3

`define PORT_COMBO_NONE 2'h0
`define PORT_COMBO_PAIR 2'h1
`define PORT_COMBO_TRIO 2'h2
`define PORT_COMBO_ALL4 2'h3

`define CLK_HZ 10000000
`define CLK_PER_MS (`CLK_HZ / 1000)
`define PORT_HOLD_MS 2000
`define PIN_HOLD_MS 2

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ### sim/supply_detect_load_mode_ctrl_monitor.sv
// Purpose: Port checker for supply/load control
// Assumes: One ref_clk domain
// Notes: Bound to the top module
`timescale 1ns/1ns
module supply_detect_monitor (
  // Clock and reset
  input wire ref_clk,
  input wire arst_n,
  // Bus handshakes
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  // Reset sources and merged initial reset
  input wire oscRunning,
  input wire watchdogReset,
  input wire initialReset,
  // Controls
  input wire heavyLoadMode,
  input wire biasRegulateLevelOne,
  input wire lcdBlankAll,
  input wire lcdLightAll,
  input wire lcdDutySelect,
  input wire detectorOn
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  property p_defaults;
    $past(initialReset, 2) |-> lcdBlankAll && !lcdLightAll && !lcdDutySelect
      && !heavyLoadMode && !detectorOn;
  endproperty
  property p_bias;
    biasRegulateLevelOne == heavyLoadMode;
  endproperty
  property p_wdog;
    watchdogReset |-> ##[1:4] initialReset;
  endproperty
  property p_osc;
    !oscRunning |-> ##[1:4] initialReset;
  endproperty
  property p_wr_resp;
    s_wr_taken |-> ##[1:3] s_axi_bvalid;
  endproperty
  property p_rd_resp;
    s_rd_taken |=> s_axi_rvalid;
  endproperty
  property p_b_once;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  property p_r_once;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
  endproperty
  a_defaults: assert property (p_defaults) else $error("defaults lost in reset");
  a_bias: assert property (p_bias) else $error("bias level wrong");
  a_wdog: assert property (p_wdog) else $error("watchdog reset missed");
  a_osc: assert property (p_osc) else $error("oscillator reset missed");
  a_wr_resp: assert property (p_wr_resp) else $error("no write response");
  a_rd_resp: assert property (p_rd_resp) else $error("no read response");
  a_b_once: assert property (p_b_once) else $error("write response repeated");
  a_r_once: assert property (p_r_once) else $error("read response repeated");
endmodule
bind supply_detect_load_mode_ctrl supply_detect_monitor u_supply_detect_monitor (.*);

// ### sim/tb_supply_detect_load_mode_ctrl.sv
// Purpose: Self-checking bench for supply/load control
// Assumes: Hold counts shortened to 8 and 16 cycles
// Notes: Driver queues bus results, a monitor matches them
`timescale 1ns/1ns
`include "supply_detect_regs.vh"
module tb_supply_detect_load_mode_ctrl;
  logic ref_clk = 0, arst_n = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, supplyBelowCrit = 0, resetPin_n = 1;
  logic oscRunning = 1, watchdogReset = 0, seen = 0, aOk, bOk, wOk;
  logic [13:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0;
  logic [3:0] s_axi_wstrb = 4'hF, inputPortLowPins = 4'hF, v;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, initialReset;
  wire detectorOn, heavyLoadMode, biasRegulateLevelOne, lcdDutySelect, lcdLightAll, lcdBlankAll;
  wire [1:0] s_axi_bresp, s_axi_rresp, thresholdSelect;
  wire [31:0] s_axi_rdata;
  int errors = 0, n_checks = 0, i, n;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  supply_detect_load_mode_ctrl #(.PIN_HOLD_CYCLES(8), .PORT_HOLD_CYCLES(16))
    u_supply_detect_load_mode_ctrl (.*);
  task chk(input string nm, input [33:0] got, input [33:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value %s exp %h seen %h", nm, exp, got);
    end
  endtask
  task close_out;
    $display("errors %0d checks %0d", errors, n_checks);
    if (errors == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task wr(input [13:0] a, input [3:0] d, input [1:0] r);
    bq.push_back(r);
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {28'h0, d};
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    n = 0;
    do
    begin
      @(negedge ref_clk);
      aOk = s_axi_awvalid && s_axi_awready === 1'b1;
      wOk = s_axi_wvalid && s_axi_wready === 1'b1;
      bOk = s_axi_bvalid === 1'b1;
      @(posedge ref_clk);
      if (aOk) s_axi_awvalid <= 0;
      if (wOk) s_axi_wvalid <= 0;
      n++;
    end while (!bOk && n < 50);
    if (!bOk) errors++;
    s_axi_bready <= 0;
  endtask
  task rd(input [13:0] a, input [1:0] r, input [3:0] d);
    rq.push_back({r, 28'h0, d});
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    n = 0;
    do
    begin
      @(negedge ref_clk);
      aOk = s_axi_arvalid && s_axi_arready === 1'b1;
      bOk = s_axi_rvalid === 1'b1;
      @(posedge ref_clk);
      if (aOk) s_axi_arvalid <= 0;
      n++;
    end while (!bOk && n < 50);
    if (!bOk) errors++;
    s_axi_rready <= 0;
  endtask
  // Sources packed as pin, port pins, osc, watchdog
  task hit(input [6:0] s, input int cyc, input bit e);
    @(posedge ref_clk);
    {resetPin_n, inputPortLowPins, oscRunning, watchdogReset} <= s;
    seen <= 0;
    repeat (cyc) @(posedge ref_clk);
    {resetPin_n, inputPortLowPins, oscRunning, watchdogReset} <= 7'h7E;
    repeat (30) @(posedge ref_clk);
    chk("initialReset", seen, e);
  endtask
  always @(negedge ref_clk)
  begin
    if (s_axi_bvalid === 1'b1 && s_axi_bready) chk("bresp", s_axi_bresp, bq.pop_front());
    if (s_axi_rvalid === 1'b1 && s_axi_rready) chk("read", {s_axi_rresp, s_axi_rdata}, rq.pop_front());
    if (initialReset === 1'b1) seen <= 1;
  end
  initial forever #50 ref_clk = ~ref_clk;
  initial
  begin
    #(20000 * 100);
    errors++;
    close_out;
  end
  initial
  begin
    v = $urandom(45);
    repeat (5) @(posedge ref_clk);
    arst_n <= 1;
    repeat (10) @(posedge ref_clk);
    chk("detectorOn", detectorOn, 0);
    rd(`ADDR_LCD_LOAD, 0, 4'h8);
    for (i = 0; i < 4; i++)
    begin
      v = $urandom;
      supplyBelowCrit <= v[0];
      wr(`ADDR_SUPPLY, {~v[0], 1'b1, i[1:0]}, 0);
      repeat (1000) @(posedge ref_clk);
      chk("thresholdSelect", thresholdSelect, i[1:0]);
      chk("detectorOn", detectorOn, 1);
      rd(`ADDR_SUPPLY, 0, {v[0], 1'b1, i[1:0]});
      supplyBelowCrit <= 0;
      wr(`ADDR_SUPPLY, {v[1], 1'b0, i[1:0]}, 0);
      rd(`ADDR_SUPPLY, 0, {1'b1, 1'b0, i[1:0]});
      wr(`ADDR_LCD_LOAD, v, 0);
      rd(`ADDR_LCD_LOAD, 0, v);
      chk("heavyLoadMode", heavyLoadMode, v[0]);
      chk("bias", biasRegulateLevelOne, v[0]);
      chk("lcdDutySelect", lcdDutySelect, v[1]);
      chk("lcdLightAll", lcdLightAll, v[2]);
      chk("lcdBlankAll", lcdBlankAll, v[3]);
    end
    wr(14'h0100, 4'hF, `RESP_SLVERR);
    rd(14'h0100, `RESP_SLVERR, 0);
    wr(`ADDR_LCD_LOAD, 4'h7, 0);
    s_axi_wstrb <= 4'hE;
    wr(`ADDR_LCD_LOAD, 4'h0, 0);
    s_axi_wstrb <= 4'hF;
    rd(`ADDR_LCD_LOAD, 0, 4'h7);
    hit(7'h7F, 1, 1);
    rd(`ADDR_LCD_LOAD, 0, 4'h8);
    hit(7'h3E, 3, 0);
    hit(7'h3E, 20, 1);
    hit(7'h46, 40, 0);
    hit(7'h42, 5, 0);
    hit(7'h42, 40, 1);
    hit(7'h7C, 3, 1);
    rd(`ADDR_RESET_STATUS, 0, 4'hF);
    close_out;
  end
endmodule
